/* File: shared/pcrs_consts.svh */
// offsets, field positions, reset values and widths of the counter and stack
`ifndef PCRS_CONSTS_SVH
`define PCRS_CONSTS_SVH
`define PCRS_PC_W          21
`define PCRS_PTR_W         5
`define PCRS_STK_DEPTH     31
`define PCRS_PTR_MAX       5'h1F
`define PCRS_PTR_RST       5'h00
`define PCRS_PC_RST        21'h000000
`define PCRS_LAT_RST       8'h00
`define PCRS_PC_STEP       21'h000002
`define PCRS_OFF_PCL       4'h0
`define PCRS_OFF_HLAT      4'h1
`define PCRS_OFF_ULAT      4'h2
`define PCRS_OFF_STACK_TOP_LOW_BYTE      4'h3
`define PCRS_OFF_STACK_TOP_HIGH_BYTE      4'h4
`define PCRS_OFF_STACK_TOP_UPPER_BYTE      4'h5
`define PCRS_OFF_PTR       4'h6
`define PCRS_OFF_STAT      4'h7
`define PCRS_OFF_CTRL      4'h8
`define PCRS_OFF_PCFULL    4'h9
`define PCRS_STAT_UNF_BIT  0
`define PCRS_STAT_OVF_BIT  1
`define PCRS_CTRL_PUSH_BIT 0
`define PCRS_CTRL_POP_BIT  1
`endif

/* File: shared/pcrs_pkg.sv */
// types and helpers shared by the counter and stack files
`include "pcrs_consts.svh"
package pcrs_pkg;
    typedef logic [`PCRS_PC_W-1:0]  pcrs_pc_t;
    typedef logic [`PCRS_PTR_W-1:0] pcrs_ptr_t;
    typedef logic [7:0]             pcrs_byte_t;
    typedef enum logic {PCRS_BUS_IDLE, PCRS_BUS_ACK} pcrs_bus_e;

    function automatic logic [31:0] pcrs_word(input pcrs_byte_t b);
        pcrs_word = {24'h000000, b};
    endfunction : pcrs_word

    // replace one byte lane of a 21-bit entry, lane 2 keeps 5 bits
    function automatic pcrs_pc_t pcrs_merge(input pcrs_pc_t v, input logic [1:0] lane,
                                            input pcrs_byte_t b);
        pcrs_merge = v;
        case (lane)
            2'h0:    pcrs_merge[7:0] = b;
            2'h1:    pcrs_merge[15:8] = b;
            2'h2:    pcrs_merge[20:16] = b[4:0];
            default: pcrs_merge = v;
        endcase
    endfunction : pcrs_merge
endpackage : pcrs_pkg

/* File: shared/pcrs_stk_if.sv */
// carrier between the counter logic and the stack storage
`timescale 1ns/1ps
interface pcrs_stk_if;
    import pcrs_pkg::*;
    logic      ce;
    logic      we;
    pcrs_ptr_t waddr;
    pcrs_pc_t  wdata;
    pcrs_ptr_t raddr;
    pcrs_pc_t  rdata;
    modport ctrl (output ce, we, waddr, wdata, raddr, input rdata);
    modport mem  (input ce, we, waddr, wdata, raddr, output rdata);
endinterface : pcrs_stk_if

/* File: src/pcrs_stack_mem.sv */
// return stack storage, entries 1..31, registered write-first read
`timescale 1ns/1ps
`include "pcrs_consts.svh"
module pcrs_stack_mem
    import pcrs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    pcrs_stk_if.mem  stk
);
    pcrs_pc_t ram [1:`PCRS_STK_DEPTH];
    pcrs_pc_t rdata_q;

    wire      wr_ok  = stk.we && (stk.waddr != `PCRS_PTR_RST);
    wire      wr_hit = wr_ok && (stk.waddr == stk.raddr);
    // pointer zero has no storage behind it and reads as zero
    wire pcrs_pc_t rdata_d = (stk.raddr == `PCRS_PTR_RST) ? `PCRS_PC_RST :
                             wr_hit ? stk.wdata : ram[stk.raddr];

    always_ff @(posedge clk) begin
        if (stk.ce && wr_ok) begin
            ram[stk.waddr] <= stk.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_q <= `PCRS_PC_RST;
        end else if (stk.ce) begin
            rdata_q <= rdata_d;
        end
    end

    assign stk.rdata = rdata_q;
endmodule : pcrs_stack_mem

/* File: src/pcrs_top.sv */
// program counter with holding latches and hardware return stack
`timescale 1ns/1ps
`include "pcrs_consts.svh"
module pcrs_top
    import pcrs_pkg::*;
(
    // clock, reset and the freeze enable
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,

    // register bus, word addressed
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    // only lane zero matters, a write without it is answered, not applied
    input  wire logic [3:0]  avs_byteenable,
    output      logic [31:0] avs_readdata,
    output      logic        avs_waitrequest,

    // sequencer and interrupt acknowledge
    input  wire logic        seq_advance,
    input  wire logic        seq_load,
    input  wire logic        seq_call,
    input  wire logic        seq_return,
    input  wire logic        irq_ack,
    input  wire pcrs_pc_t    seq_target,

    // counter and stack state, all registered
    output      pcrs_pc_t    pc_out,
    output      pcrs_ptr_t   stack_ptr_out,
    output      logic        stack_overflow,
    output      logic        stack_underflow
);

    // ---- return stack storage

    pcrs_stk_if stk ();

    pcrs_stack_mem u_mem (
        .clk    (clk),
        .resetn (resetn),
        .stk    (stk)
    );

    // bus handshake state
    pcrs_bus_e   bus_q;
    pcrs_bus_e   bus_d;
    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    // counter, latches, pointer and flags
    pcrs_pc_t    pc_q;
    pcrs_pc_t    pc_d;
    pcrs_byte_t  hlat_q;
    pcrs_byte_t  hlat_d;
    logic [4:0]  ulat_q;
    logic [4:0]  ulat_d;
    pcrs_ptr_t   ptr_q;
    pcrs_ptr_t   ptr_d;
    logic        ovf_q;
    logic        ovf_d;
    logic        unf_q;
    logic        unf_d;

    // ---- bus side

    // one fixed wait state: accept at the first edge, act at the second,
    // so every access costs exactly two edges whatever the register
    wire        req     = avs_read || avs_write;
    wire        start   = (bus_q == PCRS_BUS_IDLE) && req;
    wire        acc     = (bus_q == PCRS_BUS_ACK);
    // effects land only on the edge where waitrequest is seen low
    // the master still holds address and data at that second edge,
    // so nothing needs to be captured at the accept edge for a write
    wire        wr_fire = acc && avs_write && avs_byteenable[0];
    wire        rd_fire = acc && avs_read;
    wire pcrs_byte_t wb = avs_writedata[7:0];

    // offset compare, shared by every register select
    function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    wire sel_pcl    = reg_hit(avs_address, `PCRS_OFF_PCL);
    wire sel_hlat   = reg_hit(avs_address, `PCRS_OFF_HLAT);
    wire sel_ulat   = reg_hit(avs_address, `PCRS_OFF_ULAT);

    wire sel_stack_top_low_byte   = reg_hit(avs_address, `PCRS_OFF_STACK_TOP_LOW_BYTE);
    wire sel_stack_top_high_byte   = reg_hit(avs_address, `PCRS_OFF_STACK_TOP_HIGH_BYTE);
    wire sel_stack_top_upper_byte   = reg_hit(avs_address, `PCRS_OFF_STACK_TOP_UPPER_BYTE);

    wire sel_ptr    = reg_hit(avs_address, `PCRS_OFF_PTR);
    wire sel_stat   = reg_hit(avs_address, `PCRS_OFF_STAT);
    wire sel_ctrl   = reg_hit(avs_address, `PCRS_OFF_CTRL);
    wire sel_pcfull = reg_hit(avs_address, `PCRS_OFF_PCFULL);

    wire wr_pcl  = wr_fire && sel_pcl;
    wire wr_hlat = wr_fire && sel_hlat;
    wire wr_ulat = wr_fire && sel_ulat;
    wire wr_ptr  = wr_fire && sel_ptr;
    wire wr_stat = wr_fire && sel_stat;
    wire rd_pcl  = rd_fire && sel_pcl;
    wire wr_tos  = wr_fire && (sel_stack_top_low_byte || sel_stack_top_high_byte || sel_stack_top_upper_byte);

    // lane picks which byte of the top entry a software write replaces
    wire [1:0] tos_lane = sel_stack_top_upper_byte ? 2'h2 : sel_stack_top_high_byte ? 2'h1 : 2'h0;

    // both control bits at once count as a push, see push_req
    wire sw_push = wr_fire && sel_ctrl && wb[`PCRS_CTRL_PUSH_BIT];
    wire sw_pop  = wr_fire && sel_ctrl && wb[`PCRS_CTRL_POP_BIT];

    wire pcrs_pc_t stack_top_entry = stk.rdata;

    // byte views of the counter and of the top entry
    wire pcrs_byte_t pc_low_b    = pc_q[7:0];
    wire pcrs_byte_t pc_high_b   = pc_q[15:8];
    wire [4:0]       pc_upper_b  = pc_q[20:16];
    wire pcrs_byte_t top_low_b   = stack_top_entry[7:0];
    wire pcrs_byte_t top_high_b  = stack_top_entry[15:8];
    wire [4:0]       top_upper_b = stack_top_entry[20:16];

    // top entry as three bytes, unmapped offsets read zero
    wire [31:0] rd_mux =
        sel_pcl    ? pcrs_word(pc_low_b) :
        sel_hlat   ? pcrs_word(hlat_q) :
        sel_ulat   ? pcrs_word({3'h0, ulat_q}) :
        sel_stack_top_low_byte   ? pcrs_word(top_low_b) :
        sel_stack_top_high_byte   ? pcrs_word(top_high_b) :
        sel_stack_top_upper_byte   ? pcrs_word({3'h0, top_upper_b}) :
        sel_ptr    ? pcrs_word({3'h0, ptr_q}) :
        sel_stat   ? {30'h00000000, ovf_q, unf_q} :
        sel_pcfull ? {11'h000, pc_q} :
        32'h00000000;

    assign bus_d   = start ? PCRS_BUS_ACK : PCRS_BUS_IDLE;
    // waitrequest drops for the single cycle after the accept edge
    assign wait_d  = !start;
    // read data is captured at the accept edge and stands until the next read
    assign rdata_d = (start && avs_read) ? rd_mux : rdata_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_q <= PCRS_BUS_IDLE;
        end else if (ce) begin
            bus_q <= bus_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wait_q <= 1'b1;
        end else if (ce) begin
            wait_q <= wait_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_q <= 32'h00000000;
        end else if (ce) begin
            rdata_q <= rdata_d;
        end
    end

    // ---- stack pointer and push/pop

    // the pointer never wraps: a push at the top or a pop at zero only
    // raises its sticky flag, so a runaway call chain cannot overwrite
    // the oldest return address silently

    // a push from any source outranks a pop in the same cycle
    wire push_req = seq_call || irq_ack || sw_push;
    wire pop_req  = !push_req && (seq_return || sw_pop);
    // full means every one of the 31 entries holds a return address;
    // empty is the reset value, with no storage behind it
    wire full     = (ptr_q == `PCRS_PTR_MAX);
    wire empty    = (ptr_q == `PCRS_PTR_RST);
    wire push_ok  = push_req && !full;
    wire pop_ok   = pop_req && !empty;
    wire ovf_evt  = push_req && full;
    wire unf_evt  = pop_req && empty;

    // pointer moves by one; the ends are gated by callers, so it never wraps
    function automatic pcrs_ptr_t ptr_move(input pcrs_ptr_t p, input logic up);
        if (up) begin
            ptr_move = p + 5'h01;
        end else begin
            ptr_move = p - 5'h01;
        end
    endfunction : ptr_move

    wire pcrs_ptr_t ptr_inc = ptr_move(ptr_q, 1'b1);
    wire pcrs_ptr_t ptr_dec = ptr_move(ptr_q, 1'b0);

    // software pointer writes win: the core is stalled during them
    assign ptr_d = wr_ptr  ? wb[4:0] :
                   push_ok ? ptr_inc :
                   pop_ok  ? ptr_dec :
                   ptr_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ptr_q <= `PCRS_PTR_RST;
        end else if (ce) begin
            ptr_q <= ptr_d;
        end
    end

    // the pushed value is the counter, already at the next instruction
    // storage freezes with the rest of the block
    assign stk.ce    = ce;
    // pointer zero is filtered inside the storage, so writes there drop
    assign stk.we    = wr_tos || push_ok;
    assign stk.waddr = wr_tos ? ptr_q : ptr_inc;
    // software top entry writes replace one lane and keep the other two
    assign stk.wdata = wr_tos ? pcrs_merge(stack_top_entry, tos_lane, wb)
                              : pc_q;
    // reading at the next pointer keeps the top entry current every cycle
    assign stk.raddr = ptr_d;

    // ---- status flags, write one to clear, a new event wins

    wire clr_ovf = wr_stat && wb[`PCRS_STAT_OVF_BIT];
    wire clr_unf = wr_stat && wb[`PCRS_STAT_UNF_BIT];

    // a new event outranks a clear in the same cycle
    function automatic logic sticky(input logic evt, input logic cur, input logic clr);
        sticky = evt || (cur && !clr);
    endfunction : sticky

    assign ovf_d = sticky(ovf_evt, ovf_q, clr_ovf);
    assign unf_d = sticky(unf_evt, unf_q, clr_unf);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ovf_q <= 1'b0;
        end else if (ce) begin
            ovf_q <= ovf_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            unf_q <= 1'b0;
        end else if (ce) begin
            unf_q <= unf_d;
        end
    end

    // ---- holding latches

    // calls and returns never touch the latches
    // a low byte read snapshots the upper bytes, so a later low byte write
    // rebuilds the same address; a latch write in that cycle loses
    assign hlat_d = rd_pcl  ? pc_high_b :
                    wr_hlat ? wb :
                    hlat_q;
    assign ulat_d = rd_pcl  ? pc_upper_b :
                    wr_ulat ? wb[4:0] :
                    ulat_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hlat_q <= `PCRS_LAT_RST;
        end else if (ce) begin
            hlat_q <= hlat_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ulat_q <= 5'h00;
        end else if (ce) begin
            ulat_q <= ulat_d;
        end
    end

    // ---- program counter

    // a low byte write is a computed jump through the latches
    wire pcrs_pc_t pc_latched = {ulat_q, hlat_q, wb};
    // the step wraps at the top of the 21-bit space
    wire pcrs_pc_t pc_step    = pc_q + `PCRS_PC_STEP;
    // an interrupt acknowledge loads its vector as a call loads its target
    wire           seq_jump   = seq_call || irq_ack || seq_load;

    // priority: software low byte write, return, call or jump, step;
    // the sequencer never asks for two of these at once, the order only
    // decides what a misbehaving core would see
    wire pcrs_pc_t pc_next =
        wr_pcl     ? pc_latched :
        seq_return ? stack_top_entry :
        seq_jump   ? seq_target :
        seq_advance ? pc_step :
        pc_q;

    // bit zero is tied low whatever the source
    assign pc_d = {pc_next[20:1], 1'b0};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pc_q <= `PCRS_PC_RST;
        end else if (ce) begin
            pc_q <= pc_d;
        end
    end

    // ---- outputs, all straight from flops
    // nothing combinational reaches a port, so the sequencer can use
    // these late in its own cycle without a timing hazard

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pc_out          = pc_q;
    assign stack_ptr_out   = ptr_q;
    assign stack_overflow  = ovf_q;
    assign stack_underflow = unf_q;

endmodule : pcrs_top

/* File: verif/pcrs_top_props.sv */
// assertions on the counter and return stack ports
`timescale 1ns/1ps
module pcrs_top_props
    import pcrs_pkg::*;
(
    input wire logic      clk,
    input wire logic      resetn,
    input wire logic      ce,
    input wire logic      avs_read,
    input wire logic      avs_write,
    input wire logic      avs_waitrequest,
    input wire logic      seq_advance,
    input wire logic      seq_load,
    input wire logic      seq_call,
    input wire logic      seq_return,
    input wire logic      irq_ack,
    input wire pcrs_pc_t  seq_target,
    input wire pcrs_pc_t  pc_out,
    input wire pcrs_ptr_t stack_ptr_out,
    input wire logic      stack_overflow,
    input wire logic      stack_underflow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // bus writes outrank the sequencer on the counter and pointer, so cycles with one are left out
    wire q     = ce && !avs_write;
    wire call  = seq_call || irq_ack;
    wire push  = q && call && !seq_return;
    wire pop   = q && seq_return && !call;
    wire jmp   = q && seq_load && !call && !seq_return;
    wire adv   = q && seq_advance && !seq_load && !call && !seq_return;
    wire full  = stack_ptr_out == 5'h1F;
    wire empty = stack_ptr_out == 5'h00;

    property p_lsb; pc_out[0] == 1'b0; endproperty
    a_lsb: assert property (p_lsb) else $error("pc bit 0 set");
    property p_step; adv |=> pc_out == $past(pc_out) + 21'h2; endproperty
    a_step: assert property (p_step) else $error("pc step wrong");
    property p_jump; jmp |=> pc_out == ($past(seq_target) & 21'h1FFFFE); endproperty
    a_jump: assert property (p_jump) else $error("pc load wrong");
    property p_push; push && !full |=> stack_ptr_out == $past(stack_ptr_out) + 5'h1; endproperty
    a_push: assert property (p_push) else $error("push pointer wrong");
    property p_pop; pop && !empty |=> stack_ptr_out == $past(stack_ptr_out) - 5'h1; endproperty
    a_pop: assert property (p_pop) else $error("pop pointer wrong");
    property p_ovf; push && full |=> stack_overflow && full; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow missed");
    property p_unf; pop && empty |=> stack_underflow && empty && pc_out == 21'h0; endproperty
    a_unf: assert property (p_unf) else $error("underflow missed");
    property p_wait; ce && (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("bus answer wrong");
endmodule : pcrs_top_props

bind pcrs_top pcrs_top_props u_props (.*);

/* File: verif/pcrs_seq_model.sv */
// sequencer and interrupt acknowledge stand-in, one pulse per op code
`timescale 1ns/1ps
module pcrs_seq_model
    import pcrs_pkg::*;
(
    input  wire logic [2:0] op,
    input  wire logic       irq_mask,
    input  wire pcrs_pc_t   tgt,
    output      logic       seq_advance,
    output      logic       seq_load,
    output      logic       seq_call,
    output      logic       seq_return,
    output      logic       irq_ack,
    output      pcrs_pc_t   seq_target
);
    assign seq_advance = op == 3'h1;
    assign seq_load    = op == 3'h2;
    assign seq_call    = op == 3'h3;
    assign seq_return  = op == 3'h4;
    // no acknowledge while software owns the stack
    assign irq_ack     = op == 3'h5 && !irq_mask;
    assign seq_target  = tgt;
endmodule : pcrs_seq_model

/* File: verif/pcrs_top_test.sv */
// random and corner stimulus for the counter and return stack
`timescale 1ns/1ps
module pcrs_top_test;
    import pcrs_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1, rd = 1'b0, wr = 1'b0;
    logic        irq_mask = 1'b0, wq, ovf, unf, sa, sl, sc, sr, ia;
    logic        r_ovf = 1'b0, r_unf = 1'b0;
    logic [2:0]  op = 3'h0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, v, seed = 32'h00000D3A;
    pcrs_pc_t    tgt = 21'h0, st, pc_out, r_pc = 21'h0, r_stk [32];
    pcrs_ptr_t   ptr, r_ptr = 5'h00;
    int          err_count = 0, n_tests = 0, cyc = 0;

    always #50 clk = ~clk;

    pcrs_seq_model u_seq (.op(op), .irq_mask(irq_mask), .tgt(tgt), .seq_advance(sa),
        .seq_load(sl), .seq_call(sc), .seq_return(sr), .irq_ack(ia), .seq_target(st));
    pcrs_top DUT (.clk(clk), .resetn(resetn), .ce(ce), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wq), .seq_advance(sa), .seq_load(sl), .seq_call(sc),
        .seq_return(sr), .irq_ack(ia), .seq_target(st), .pc_out(pc_out),
        .stack_ptr_out(ptr), .stack_overflow(ovf), .stack_underflow(unf));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic pcrs_pc_t al(input pcrs_pc_t t);
        return t & 21'h1FFFFE;
    endfunction : al

    task automatic test_done();
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_st();
        chk("pc", 32'(r_pc), 32'(pc_out));
        chk("ptr", 32'(r_ptr), 32'(ptr));
        chk("flags", {30'h0, r_ovf, r_unf}, {30'h0, ovf, unf});
    endtask : chk_st

    // held until waitrequest is sampled low, one idle edge after
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (wq !== 1'b0)
            @(posedge clk);
        v = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("readdata", e, v);
    endtask : rchk

    task automatic model(input logic [2:0] o, input pcrs_pc_t t);
        case (o)
            3'h1: r_pc = r_pc + 21'h2;
            3'h2: r_pc = al(t);
            3'h3, 3'h5: begin
                r_ovf = r_ovf | (r_ptr == 5'h1F);
                if (r_ptr != 5'h1F) begin
                    r_ptr++;
                    r_stk[r_ptr] = r_pc;
                end
                r_pc = al(t);
            end
            3'h4: begin
                r_unf = r_unf | (r_ptr == 5'h00);
                r_pc = (r_ptr == 5'h00) ? 21'h0 : al(r_stk[r_ptr]);
                if (r_ptr != 5'h00)
                    r_ptr--;
            end
            default: ;
        endcase
    endtask : model

    // checks the previous op's result, so ops run back to back
    task automatic step(input logic [2:0] o, input pcrs_pc_t t, input logic c);
        op <= o;
        tgt <= t;
        ce <= c;
        @(negedge clk);
        chk_st();
        @(posedge clk);
        if (c)
            model(o, t);
    endtask : step

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        step(3'h4, 21'h0, 1'b1);
        for (int i = 0; i < 32; i++)
            step(3'h3, pcrs_pc_t'(i * 6 + 3), 1'b1);
        for (int i = 0; i < 31; i++)
            step(3'h4, 21'h0, 1'b1);
        step(3'h0, 21'h0, 1'b1);
        bus(1'b1, 4'h1, 32'h000000A5);
        bus(1'b1, 4'h2, 32'h0000001C);
        for (int i = 0; i < 400; i++) begin
            seed = xs(seed);
            step(seed[2:0] % 3'h6, seed[31:11], seed[7:4] != 4'h0);
        end
        step(3'h0, 21'h0, 1'b1);
        irq_mask <= 1'b1;
        rchk(4'h1, 32'h000000A5);
        rchk(4'h2, 32'h0000001C);
        rchk(4'h0, 32'(r_pc[7:0]));
        rchk(4'h1, 32'(r_pc[15:8]));
        rchk(4'h2, 32'(r_pc[20:16]));
        seed = xs(seed);
        bus(1'b1, 4'h1, seed);
        bus(1'b1, 4'h2, seed >> 8);
        bus(1'b1, 4'h0, seed >> 16);
        r_pc = {seed[12:8], seed[7:0], seed[23:17], 1'b0};
        rchk(4'h9, 32'(r_pc));
        rchk(4'hF, 32'h0);
        bus(1'b1, 4'h6, 32'h3);
        bus(1'b1, 4'h3, seed);
        bus(1'b1, 4'h4, seed >> 8);
        bus(1'b1, 4'h5, seed >> 16);
        r_ptr = 5'h03;
        r_stk[3] = seed[20:0];
        rchk(4'h5, 32'(seed[20:16]));
        rchk(4'h6, 32'h3);
        bus(1'b1, 4'h8, 32'h1);
        rchk(4'h3, 32'(r_pc[7:0]));
        bus(1'b1, 4'h8, 32'h2);
        irq_mask <= 1'b0;
        step(3'h4, 21'h0, 1'b1);
        step(3'h0, 21'h0, 1'b1);
        rchk(4'h7, {30'h0, r_ovf, r_unf});
        bus(1'b1, 4'h7, 32'h3);
        rchk(4'h7, 32'h0);
        test_done();
    end
endmodule : pcrs_top_test
